/* File: rtl/bcs_defines.svh */
// Constants for the bus clock, slow mode and pin configuration block
`ifndef BCS_DEFINES_SVH
`define BCS_DEFINES_SVH

// ----------------------------------------------------------------
// Clock division, misc register address and stop stabilisation count
// ----------------------------------------------------------------
`define BCS_NORM_DIV      6'd2
`define BCS_SLOW_DIV      6'd32
`define BCS_MISC_ADDR     16'h000C
`define BCS_STOP_STAB_CYC 4064

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BCS_RST_SLOW      1'b0
`define BCS_RST_TRIG      2'h0
`define BCS_RST_IRQ_EN    1'b0
`define BCS_RST_PORT_DIR  8'h00

`endif

/* File: rtl/bcs_pkg.sv */
// Types for the bus clock, slow mode and pin configuration block
package bcs_pkg;
  typedef enum logic [1:0] {
    BCS_TRIG_FALL,
    BCS_TRIG_RISE,
    BCS_TRIG_BOTH,
    BCS_TRIG_LEVEL
  } bcs_trig_t;
endpackage

/* File: rtl/bcs_clk_if.sv */
// Interface carrying divider control and phase between the modules
`timescale 1ns/1ps
interface bcs_clk_if;
  logic       slow_mode;
  logic       bus_clk;
  logic       bus_tick;
  logic       at_bound;
  modport ctrl (output slow_mode, input bus_clk, input bus_tick, input at_bound);
  modport div  (input slow_mode, output bus_clk, output bus_tick, output at_bound);
endinterface

/* File: rtl/bcs_clk_div.sv */
// Glitch-free bus clock divider, oscillator by 2 or by 32
`timescale 1ns/1ps
`include "bcs_defines.svh"
module bcs_clk_div
  import bcs_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic rst_sync_n_in,
  bcs_clk_if.div    dif
);

  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic       slow_ff;
  logic       nxt_slow;
  logic       clk_ff;
  logic       nxt_clk;
  logic       tick_ff;
  logic       nxt_tick;
  logic [4:0] last;

  // Divider end count for the mode in force
  assign last = slow_ff ? 5'(`BCS_SLOW_DIV - 6'd1) : 5'(`BCS_NORM_DIV - 6'd1);

  // Mode sampled only at period end so no pulse is cut short
  always_comb begin
    nxt_cnt  = cnt_ff + 5'd1;
    nxt_slow = slow_ff;
    nxt_tick = 1'b0;
    if (cnt_ff >= last) begin
      nxt_cnt  = 5'd0;
      nxt_slow = dif.slow_mode;
      nxt_tick = 1'b1;
    end
    nxt_clk = (nxt_cnt < (nxt_slow ? 5'd16 : 5'd1));
  end

  always_ff @(posedge mclk_in or negedge rst_sync_n_in) begin
    if (!rst_sync_n_in) begin
      cnt_ff  <= 5'd0;
      slow_ff <= `BCS_RST_SLOW;
      clk_ff  <= 1'b1;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      slow_ff <= nxt_slow;
      clk_ff  <= nxt_clk;
      tick_ff <= nxt_tick;
    end
  end

  assign dif.bus_clk  = clk_ff;
  assign dif.bus_tick = tick_ff;
  assign dif.at_bound = (cnt_ff == 5'd0);

  // Period spacing check
  logic [5:0] gap_ff;
  always_ff @(posedge mclk_in or negedge rst_sync_n_in) begin
    if (!rst_sync_n_in) gap_ff <= 6'd0;
    else if (tick_ff) gap_ff <= 6'd1;
    else if (gap_ff != 6'd63) gap_ff <= gap_ff + 6'd1;
  end
  tick_spacing_a: assert property (@(posedge mclk_in) disable iff (!rst_sync_n_in)
    tick_ff && gap_ff != 6'd0 |-> gap_ff == 6'd2 || gap_ff == 6'd32)
    else $error("bus period not 2 or 32 oscillator cycles");
endmodule

/* File: rtl/bcs_top.sv */
// Bus clock generation, slow mode, external interrupt and pin configuration
//
// Overview of operation
// - Slow mode set gives bus clock of oscillator divided by 32
// - Slow mode clear gives bus clock of oscillator divided by 2
// - The bus clock and tick only reach the outputs and port C bit two; all control state runs on the oscillator
// - External or power-on reset clears slow mode
// - Entering stop clears slow mode automatically
// - Interrupt pin sensed in one of four modes from two sense bits
// - Enable bit can block all external interrupt requests
// - Sense bit writes accepted only while interrupt mask is set
// - Changing sense mode discards a pending external request
// - Low on reset pin forces the defined start-up state
// - Internal reset drives reset pin low, open drain
// - Three 8-bit ports have programmable direction, inputs after reset
// - Port C bit two may output the bus clock
// - Port D is converter input when enabled; reset disables converter
// - Slow mode bit lives in misc register at 000C, before clock driver
// - Stop clears slow mode so stop exit count runs at nominal speed
`timescale 1ns/1ps
`include "bcs_defines.svh"
module bcs_top
  import bcs_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        wdog_rst_in,
  input  wire logic        stop_enter_in,
  input  wire logic        misc_wr_in,
  input  wire logic [15:0] misc_addr_in,
  input  wire logic        slow_mode_select_in,
  input  wire logic        irq_rising_sense_sel_in,
  input  wire logic        irq_falling_sense_sel_in,
  input  wire logic        ext_irq_enable_in,
  input  wire logic        cpu_irq_mask_in,
  input  wire logic        irq_ack_in,
  input  wire logic        irq_pin_n_in,
  input  wire logic        dir_wr_in,
  input  wire logic [1:0]  dir_sel_in,
  input  wire logic [7:0]  dir_data_in,
  input  wire logic        clk_out_en_in,
  input  wire logic        adc_en_wr_in,
  input  wire logic        adc_en_in,
  output logic             bus_clk_out,
  output logic             bus_tick_out,
  output logic             slow_mode_select_out,
  output logic             ext_irq_req_out,
  output logic             reset_pin_out,
  output logic             reset_pin_oe_n_out,
  output logic             sys_rst_n_out,
  output logic [23:0]      port_dir_out,
  output logic             port_c_bit_two_clk_out,
  output logic             adc_en_out,
  output logic             analog_shared_inputs_out
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rs1_ff;
  logic rs2_ff;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rs1_ff <= 1'b0;
      rs2_ff <= 1'b0;
    end else begin
      rs1_ff <= 1'b1;
      rs2_ff <= rs1_ff;
    end
  end
  // Pin reset reaches the whole device; the watchdog only drives the reset pin
  logic rst_n;
  assign rst_n = rs2_ff;

  // ----------------------------------------------------------------
  // Divider instance
  // ----------------------------------------------------------------
  bcs_clk_if dif ();
  bcs_clk_div u_div (
    .mclk_in       (mclk_in),
    .rst_sync_n_in (rst_n),
    .dif           (dif.div)
  );

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  logic        slow_ff,     nxt_slow;
  bcs_trig_t   trig_ff,     nxt_trig;
  logic        irq_en_ff,   nxt_irq_en;
  logic        pend_ff,     nxt_pend;
  logic        pin_d_ff,    nxt_pin_d;
  logic [23:0] dir_ff,      nxt_dir;
  logic        adc_ff,      nxt_adc;
  logic        clk_ff,      nxt_clk;
  logic        tick_ff,     nxt_tick;
  logic        pc2_ff,      nxt_pc2;
  logic        rpin_oe_ff,  nxt_rpin_oe;
  logic        misc_hit;
  logic        edge_evt;
  bcs_trig_t   wr_trig;

  // Sense bits to mode: bit1 rising, bit0 falling-side level option
  function automatic bcs_trig_t sense_code(input logic rise, input logic fall);
    return bcs_trig_t'({rise, fall});
  endfunction

  assign misc_hit = misc_wr_in && (misc_addr_in == `BCS_MISC_ADDR);
  assign wr_trig  = sense_code(irq_rising_sense_sel_in, irq_falling_sense_sel_in);

  // Pin event for the mode in force; pin is active low
  always_comb begin
    case (trig_ff)
      BCS_TRIG_FALL:  edge_evt = pin_d_ff && !irq_pin_n_in;
      BCS_TRIG_RISE:  edge_evt = !pin_d_ff && irq_pin_n_in;
      BCS_TRIG_BOTH:  edge_evt = pin_d_ff != irq_pin_n_in;
      BCS_TRIG_LEVEL: edge_evt = !irq_pin_n_in;
      default:        edge_evt = 1'b0;
    endcase
  end

  // Next values for all control state
  always_comb begin
    nxt_slow    = slow_ff;
    nxt_trig    = trig_ff;
    nxt_irq_en  = irq_en_ff;
    nxt_pend    = pend_ff;
    nxt_pin_d   = irq_pin_n_in;
    nxt_dir     = dir_ff;
    nxt_adc     = adc_ff;
    nxt_clk     = dif.bus_clk;
    nxt_tick    = dif.bus_tick;
    nxt_pc2     = clk_out_en_in && dif.bus_clk;
    nxt_rpin_oe = !wdog_rst_in;
    if (misc_hit) begin
      nxt_slow   = slow_mode_select_in;
      nxt_irq_en = ext_irq_enable_in;
      if (cpu_irq_mask_in) begin
        nxt_trig = wr_trig;
      end
    end
    // Stop entry wins so stabilisation runs at nominal speed
    if (stop_enter_in) begin
      nxt_slow = 1'b0;
    end
    if (irq_ack_in) begin
      nxt_pend = 1'b0;
    end
    // A mode change discards the old request before a new one may set
    if (nxt_trig != trig_ff) begin
      nxt_pend = 1'b0;
    end else if (edge_evt && irq_en_ff) begin
      nxt_pend = 1'b1;
    end
    if (!irq_en_ff) begin
      nxt_pend = 1'b0;
    end
    if (dir_wr_in) begin
      for (int i = 0; i < 3; i++) begin
        if (dir_sel_in == 2'(i)) begin
          nxt_dir[i*8 +: 8] = dir_data_in;
        end
      end
    end
    if (adc_en_wr_in) begin
      nxt_adc = adc_en_in;
    end
  end

  // Registers; reset clears slow mode and ports go to input
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      slow_ff    <= `BCS_RST_SLOW;
      trig_ff    <= BCS_TRIG_FALL;
      irq_en_ff  <= `BCS_RST_IRQ_EN;
      pend_ff    <= 1'b0;
      pin_d_ff   <= 1'b1;
      dir_ff     <= {3{`BCS_RST_PORT_DIR}};
      adc_ff     <= 1'b0;
      clk_ff     <= 1'b1;
      tick_ff    <= 1'b0;
      pc2_ff     <= 1'b0;
      rpin_oe_ff <= 1'b1;
    end else begin
      slow_ff    <= nxt_slow;
      trig_ff    <= nxt_trig;
      irq_en_ff  <= nxt_irq_en;
      pend_ff    <= nxt_pend;
      pin_d_ff   <= nxt_pin_d;
      dir_ff     <= nxt_dir;
      adc_ff     <= nxt_adc;
      clk_ff     <= nxt_clk;
      tick_ff    <= nxt_tick;
      pc2_ff     <= nxt_pc2;
      rpin_oe_ff <= nxt_rpin_oe;
    end
  end

  assign dif.slow_mode = slow_ff;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Reset pin value is constant low; only the enable moves (open drain)
  assign reset_pin_out            = 1'b0;
  assign reset_pin_oe_n_out       = rpin_oe_ff;
  assign sys_rst_n_out            = rs2_ff;
  assign bus_clk_out              = clk_ff;
  assign bus_tick_out             = tick_ff;
  assign slow_mode_select_out     = slow_ff;
  assign ext_irq_req_out          = pend_ff;
  assign port_dir_out             = dir_ff;
  // Gated before the flop so the pin carries no combinational glitch
  assign port_c_bit_two_clk_out   = pc2_ff;
  assign adc_en_out               = adc_ff;
  assign analog_shared_inputs_out = adc_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  stop_clears_slow_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    stop_enter_in |=> !slow_ff)
    else $error("slow mode not cleared on stop");
  trig_write_gate_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    !cpu_irq_mask_in |=> $stable(trig_ff))
    else $error("sense mode changed with mask clear");
  mode_change_drop_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    $changed(trig_ff) |-> !pend_ff)
    else $error("pending request survived mode change");
  irq_disable_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    !irq_en_ff |=> !pend_ff)
    else $error("request raised while disabled");
  wdog_drive_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    wdog_rst_in |=> !reset_pin_oe_n_out && !reset_pin_out)
    else $error("reset pin not driven low");
  falling_sense_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    trig_ff == BCS_TRIG_FALL && irq_en_ff && pin_d_ff && !irq_pin_n_in
      && !irq_ack_in && !misc_hit |=> pend_ff)
    else $error("falling edge missed");
  slow_period_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    $rose(dif.bus_tick) && dif.slow_mode && u_div.slow_ff |=> !dif.bus_tick [*8])
    else $error("slow period too short");
  misc_write_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    misc_hit && !stop_enter_in |=> slow_ff == $past(slow_mode_select_in))
    else $error("slow bit write lost");
  switch_bound_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    $changed(u_div.slow_ff) |-> dif.at_bound)
    else $error("clock mode switched inside a bus period");

  slow_seen_c:  cover property (@(posedge mclk_in) disable iff (!rst_n) slow_ff && bus_tick_out);
  irq_seen_c:   cover property (@(posedge mclk_in) disable iff (!rst_n) $rose(pend_ff));
  mode_chg_c:   cover property (@(posedge mclk_in) disable iff (!rst_n) $changed(trig_ff));
endmodule

/* File: dv/bcs_top_tb_top.sv */
// Self-checking testbench for the bus clock, slow mode and pin configuration block
`timescale 1ns/1ps
module bcs_top_tb_top;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic        mclk_in = 1'h0;
  logic        rst_n_in = 1'h0;
  logic        wdog_rst_in = 1'h0;
  logic        stop_enter_in = 1'h0;
  logic        misc_wr_in = 1'h0;
  logic [15:0] misc_addr_in = 16'h0000;
  logic        slow_mode_select_in = 1'h0;
  logic        irq_rising_sense_sel_in = 1'h0;
  logic        irq_falling_sense_sel_in = 1'h0;
  logic        ext_irq_enable_in = 1'h0;
  logic        cpu_irq_mask_in = 1'h1;
  logic        irq_ack_in = 1'h0;
  logic        irq_pin_n_in = 1'h1;
  logic        dir_wr_in = 1'h0;
  logic [1:0]  dir_sel_in = 2'h0;
  logic [7:0]  dir_data_in = 8'h00;
  logic        clk_out_en_in = 1'h0;
  logic        adc_en_wr_in = 1'h0;
  logic        adc_en_in = 1'h0;
  logic        bus_clk_out, bus_tick_out, slow_mode_select_out, ext_irq_req_out;
  logic        reset_pin_out, reset_pin_oe_n_out, sys_rst_n_out;
  logic [23:0] port_dir_out;
  logic        port_c_bit_two_clk_out, adc_en_out, analog_shared_inputs_out;
  int          error_cnt = 0;
  int          checks = 0;
  int          p, hi, n;
  logic [23:0] exp_dir;

  bcs_top u_bcs_top (
    .mclk_in, .rst_n_in, .wdog_rst_in, .stop_enter_in, .misc_wr_in, .misc_addr_in,
    .slow_mode_select_in, .irq_rising_sense_sel_in, .irq_falling_sense_sel_in,
    .ext_irq_enable_in, .cpu_irq_mask_in, .irq_ack_in, .irq_pin_n_in, .dir_wr_in,
    .dir_sel_in, .dir_data_in, .clk_out_en_in, .adc_en_wr_in, .adc_en_in,
    .bus_clk_out, .bus_tick_out, .slow_mode_select_out, .ext_irq_req_out, .reset_pin_out,
    .reset_pin_oe_n_out, .sys_rst_n_out, .port_dir_out, .port_c_bit_two_clk_out,
    .adc_en_out, .analog_shared_inputs_out
  );

  // 50 MHz oscillator
  always #10 mclk_in = ~mclk_in;

  // ----------------------------------------------------------------
  // Access and checking tasks
  // ----------------------------------------------------------------
  // Inputs always move 1 ns after the edge, so sampling never races
  task automatic step(input int k = 1);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic wr_misc(input logic [15:0] a, input logic s, input logic [1:0] m,
                         input logic en);
    misc_wr_in = 1'h1;
    misc_addr_in = a;
    slow_mode_select_in = s;
    irq_rising_sense_sel_in = m[1];
    irq_falling_sense_sel_in = m[0];
    ext_irq_enable_in = en;
    step();
    misc_wr_in = 1'h0;
    step();
  endtask

  // Bus period and high time, in oscillator cycles, between two ticks
  task automatic period(output int pp, output int hh);
    int w;
    w = 0;
    while (bus_tick_out !== 1'h1 && w < 100) begin
      step();
      w++;
    end
    step();
    pp = 1;
    hh = (bus_clk_out === 1'h1);
    while (bus_tick_out !== 1'h1 && pp < 100) begin
      step();
      pp++;
      hh += (bus_clk_out === 1'h1);
    end
  endtask

  task automatic pulse_ack;
    irq_ack_in = 1'h1;
    step();
    irq_ack_in = 1'h0;
    step(2);
  endtask

  // One trigger option: falling edge, then rising edge, then acknowledge
  task automatic irq_mode(input logic [1:0] m);
    wr_misc(16'h000C, 1'h0, m, 1'h1);
    chk("irq_after_mode", ext_irq_req_out, 1'h0);
    irq_pin_n_in = 1'h0;
    step(6);
    chk("irq_on_low", ext_irq_req_out, m != bcs_pkg::BCS_TRIG_RISE);
    irq_pin_n_in = 1'h1;
    step(6);
    // Whether a level request outlives the pin going high is left open
    if (m != bcs_pkg::BCS_TRIG_LEVEL) begin
      chk("irq_on_high", ext_irq_req_out, 1'h1);
    end
    pulse_ack();
    chk("irq_acked", ext_irq_req_out, 1'h0);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    step(20);
    rst_n_in = 1'h1;
    step(3);
    chk("slow_rst", slow_mode_select_out, 1'h0);
    chk("dir_rst", port_dir_out, 24'h000000);
    chk("oe_n_rst", reset_pin_oe_n_out, 1'h1);
    chk("adc_rst", adc_en_out, 1'h0);
    chk("analog_rst", analog_shared_inputs_out, 1'h0);
    chk("pc2_rst", port_c_bit_two_clk_out, 1'h0);
    chk("sysrst_rel", sys_rst_n_out, 1'h1);
    period(p, hi);
    chk("norm_period", p, 32'h2);
    chk("norm_high", hi, 32'h1);
    // Wrong address must not touch the slow bit
    wr_misc(16'h000D, 1'h1, 2'h0, 1'h0);
    chk("slow_bad_addr", slow_mode_select_out, 1'h0);
    wr_misc(16'h000C, 1'h1, 2'h0, 1'h0);
    chk("slow_set", slow_mode_select_out, 1'h1);
    period(p, hi);
    period(p, hi);
    chk("slow_period", p, 32'h20);
    chk("slow_high", hi, 32'h10);
    clk_out_en_in = 1'h1;
    n = 0;
    repeat (40) begin
      step();
      n += (port_c_bit_two_clk_out !== bus_clk_out);
    end
    chk("pc2_clock", n, 32'h0);
    stop_enter_in = 1'h1;
    step();
    stop_enter_in = 1'h0;
    step();
    chk("slow_stop", slow_mode_select_out, 1'h0);
    period(p, hi);
    period(p, hi);
    chk("stop_period", p, 32'h2);
    // Port directions, one byte per port
    exp_dir = 24'h000000;
    for (int i = 0; i < 3; i++) begin
      dir_wr_in = 1'h1;
      dir_sel_in = i[1:0];
      dir_data_in = 8'hA5 ^ i[7:0];
      exp_dir[8*i +: 8] = 8'hA5 ^ i[7:0];
      step();
      dir_wr_in = 1'h0;
      step();
    end
    chk("dir_set", port_dir_out, exp_dir);
    adc_en_wr_in = 1'h1;
    adc_en_in = 1'h1;
    step();
    adc_en_wr_in = 1'h0;
    step();
    chk("adc_on", adc_en_out, 1'h1);
    chk("analog_on", analog_shared_inputs_out, 1'h1);
    for (int k = 0; k < 4; k++) begin
      irq_mode(k[1:0]);
    end
    // Disabled input raises nothing
    wr_misc(16'h000C, 1'h0, bcs_pkg::BCS_TRIG_FALL, 1'h0);
    irq_pin_n_in = 1'h0;
    step(6);
    chk("irq_disabled", ext_irq_req_out, 1'h0);
    irq_pin_n_in = 1'h1;
    step(6);
    // Sense write with the mask clear is dropped: falling still works
    wr_misc(16'h000C, 1'h0, bcs_pkg::BCS_TRIG_FALL, 1'h1);
    cpu_irq_mask_in = 1'h0;
    wr_misc(16'h000C, 1'h0, bcs_pkg::BCS_TRIG_RISE, 1'h1);
    irq_pin_n_in = 1'h0;
    step(6);
    chk("irq_mask_guard", ext_irq_req_out, 1'h1);
    cpu_irq_mask_in = 1'h1;
    wr_misc(16'h000C, 1'h0, bcs_pkg::BCS_TRIG_RISE, 1'h1);
    chk("irq_discard", ext_irq_req_out, 1'h0);
    irq_pin_n_in = 1'h1;
    step(6);
    pulse_ack();
    wdog_rst_in = 1'h1;
    step(3);
    chk("wdog_oe_n", reset_pin_oe_n_out, 1'h0);
    chk("wdog_level", reset_pin_out, 1'h0);
    wdog_rst_in = 1'h0;
    step(3);
    chk("wdog_release", reset_pin_oe_n_out, 1'h1);
    // Reset in mid-run with everything set
    wr_misc(16'h000C, 1'h1, 2'h0, 1'h1);
    rst_n_in = 1'h0;
    step(2);
    chk("slow_rerst", slow_mode_select_out, 1'h0);
    chk("dir_rerst", port_dir_out, 24'h000000);
    chk("adc_rerst", adc_en_out, 1'h0);
    chk("sysrst_low", sys_rst_n_out, 1'h0);
    step(18);
    rst_n_in = 1'h1;
    step(3);
    chk("sysrst_again", sys_rst_n_out, 1'h1);
    tally_and_finish();
  end

  // Whole sequence needs a few hundred cycles; far beyond that is a hang
  initial begin
    #400000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
